//--- hdl/ucc_ctrl.sv
// Serial port control, FIFO threshold and interrupt mask block with its APB slave.
// Operation
// - Receive section works only while control bit 9 is set; resets to 1.
// - Transmit section works only while control bit 8 is set; resets to 1.
// - Receive disable mid-character finishes that character before the receiver stops.
// - Transmit disable mid-character finishes that character before the transmitter stops.
// - Control bit 7 loops transmit output into receive input; resets to 0.
// - Port works only while global enable, control bit 0, is set; resets to 0.
// - Clearing global enable lets the character in progress complete first.
// - FIFO level interrupts fire on crossing the trigger level, not on the level.
// - Receive half-full trigger fires as the 9th character enters.
// - Receive code in bits 5:3 selects 1/8 to 7/8; codes 5 to 7 reserved.
// - Transmit code in bits 2:0 selects 1/8 to 7/8; codes 5 to 7 reserved.
// - Both threshold fields reset to the half-full code.
// - Each mask bit set forwards its raw interrupt; cleared blocks it.
// - Reading the mask register returns the stored mask bits.
// - Mask bits 10 to 7 gate overrun, break, parity, framing; reset 0.
// - Mask bits 6 to 4 gate time-out, transmit and receive level; reset 0.
// - Masked status reads raw state and mask combined; writes ignored.
// - Writing 1 to a clear bit clears that raw interrupt; 0 does nothing.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`include "ucc_cfg.svh"
module ucc_ctrl (
   // Clock and reset.
   input  wire logic                 core_clk_i,
   input  wire logic                 reset_i,
   // APB slave.
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [`UCC_AW-1:0]   paddr_i,
   input  wire logic [31:0]          pwdata_i,
   output logic      [31:0]          prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   // Transmit and receive engines.
   input  wire logic                 tx_busy_i,
   input  wire logic                 rx_busy_i,
   output ucc_pkg::ucc_sect_t        tx_sect_o,
   output ucc_pkg::ucc_sect_t        rx_sect_o,
   output logic                      loopback_enable_o,
   // Serial data paths.
   input  wire logic                 tx_serial_i,
   input  wire logic                 serial_in_pin_i,
   output logic                      rx_serial_o,
   output logic                      serial_out_pin_o,
   // FIFO fill levels and error events.
   input  wire logic [`UCC_LW-1:0]   tx_fifo_level_i,
   input  wire logic [`UCC_LW-1:0]   rx_fifo_level_i,
   input  wire ucc_pkg::ucc_err_evt_t err_evt_i,
   // Interrupt request to the interrupt controller.
   output logic                      irq_o
);
   import ucc_pkg::*;

   // Control and configuration state.
   logic                  global_en_reg;
   logic                  global_en_next;
   logic                  tx_sect_en_reg;
   logic                  tx_sect_en_next;
   logic                  rx_sect_en_reg;
   logic                  rx_sect_en_next;
   logic                  loopback_reg;
   logic                  loopback_next;
   logic [2:0]            rx_thr_reg;
   logic [2:0]            rx_thr_next;
   logic [2:0]            tx_thr_reg;
   logic [2:0]            tx_thr_next;
   logic [`UCC_SRC_N-1:0] mask_reg;
   logic [`UCC_SRC_N-1:0] mask_next;
   // Interrupt state.
   logic [`UCC_SRC_N-1:0] raw_reg;
   logic [`UCC_SRC_N-1:0] raw_next;
   logic [`UCC_SRC_N-1:0] src_evt;
   logic [`UCC_SRC_N-1:0] clr_bits;
   logic                  irq_reg;
   logic                  irq_next;
   logic                  rx_cross;
   logic                  tx_cross;
   // Section and pin state.
   ucc_sect_t             tx_sect_reg;
   ucc_sect_t             tx_sect_next;
   ucc_sect_t             rx_sect_reg;
   ucc_sect_t             rx_sect_next;
   logic                  rx_serial_reg;
   logic                  rx_serial_next;
   logic                  out_pin_reg;
   logic                  out_pin_next;
   // Bus state.
   logic [31:0]           prdata_reg;
   logic [31:0]           prdata_next;
   logic                  pready_reg;
   logic                  pready_next;
   logic                  pslverr_reg;
   logic                  pslverr_next;
   logic                  wr_acc;
   logic                  hit;

   // A write lands only at the edge that closes the access phase.
   assign wr_acc = psel_i & penable_i & pready_reg & pwrite_i & ~pslverr_reg;

   // Address decode for the six words of the map.
   always_comb begin
      case (paddr_i)
         `UCC_OFS_CTRL, `UCC_OFS_THR, `UCC_OFS_MASK,
         `UCC_OFS_RAW, `UCC_OFS_MIS, `UCC_OFS_CLR: hit = 1'b1;
         default:                                  hit = 1'b0;
      endcase
   end

   // Read data is built in the setup cycle so that the answer comes from a flop.
   // Status that changes between setup and access shows its setup-cycle value.
   always_comb begin
      prdata_next  = prdata_reg;
      pready_next  = psel_i & ~penable_i;
      pslverr_next = psel_i & ~penable_i & ~hit;
      if (psel_i & ~penable_i) begin
         prdata_next = 32'h0000_0000;
         case (paddr_i)
            `UCC_OFS_CTRL: begin
               prdata_next[`UCC_CTRL_RXE] = rx_sect_en_reg;
               prdata_next[`UCC_CTRL_TXE] = tx_sect_en_reg;
               prdata_next[`UCC_CTRL_LBE] = loopback_reg;
               prdata_next[`UCC_CTRL_EN]  = global_en_reg;
            end
            `UCC_OFS_THR: begin
               prdata_next[`UCC_THR_RX_MSB:`UCC_THR_RX_LSB] = rx_thr_reg;
               prdata_next[`UCC_THR_TX_MSB:`UCC_THR_TX_LSB] = tx_thr_reg;
            end
            `UCC_OFS_MASK: begin
               prdata_next[`UCC_SRC_MSB:`UCC_SRC_LSB] = mask_reg;
            end
            `UCC_OFS_RAW: begin
               prdata_next[`UCC_SRC_MSB:`UCC_SRC_LSB] = raw_reg;
               prdata_next[`UCC_SRC_LSB-1:0]          = `UCC_RAW_RSVD;
            end
            `UCC_OFS_MIS: begin
               prdata_next[`UCC_SRC_MSB:`UCC_SRC_LSB] = raw_reg & mask_reg;
            end
            default: begin
               prdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   // Bus answer registers.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Configuration writes; software is expected to disable the port before reconfiguring.
   // Writes to raw and masked status words fall through untouched.
   always_comb begin
      global_en_next  = global_en_reg;
      tx_sect_en_next = tx_sect_en_reg;
      rx_sect_en_next = rx_sect_en_reg;
      loopback_next   = loopback_reg;
      rx_thr_next     = rx_thr_reg;
      tx_thr_next     = tx_thr_reg;
      mask_next       = mask_reg;
      clr_bits        = '0;
      if (wr_acc) begin
         case (paddr_i)
            `UCC_OFS_CTRL: begin
               rx_sect_en_next = pwdata_i[`UCC_CTRL_RXE];
               tx_sect_en_next = pwdata_i[`UCC_CTRL_TXE];
               loopback_next   = pwdata_i[`UCC_CTRL_LBE];
               global_en_next  = pwdata_i[`UCC_CTRL_EN];
            end
            `UCC_OFS_THR: begin
               rx_thr_next = pwdata_i[`UCC_THR_RX_MSB:`UCC_THR_RX_LSB];
               tx_thr_next = pwdata_i[`UCC_THR_TX_MSB:`UCC_THR_TX_LSB];
            end
            `UCC_OFS_MASK: begin
               mask_next = pwdata_i[`UCC_SRC_MSB:`UCC_SRC_LSB];
            end
            `UCC_OFS_CLR: begin
               clr_bits = pwdata_i[`UCC_SRC_MSB:`UCC_SRC_LSB];
            end
            default: begin
               clr_bits = '0;
            end
         endcase
      end
   end

   // Configuration registers and their reset values.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         global_en_reg  <= `UCC_RST_EN;
         tx_sect_en_reg <= `UCC_RST_TXE;
         rx_sect_en_reg <= `UCC_RST_RXE;
         loopback_reg   <= `UCC_RST_LBE;
         rx_thr_reg     <= `UCC_THR_RST;
         tx_thr_reg     <= `UCC_THR_RST;
         mask_reg       <= `UCC_RST_MASK;
      end else begin
         global_en_reg  <= global_en_next;
         tx_sect_en_reg <= tx_sect_en_next;
         rx_sect_en_reg <= rx_sect_en_next;
         loopback_reg   <= loopback_next;
         rx_thr_reg     <= rx_thr_next;
         tx_thr_reg     <= tx_thr_next;
         mask_reg       <= mask_next;
      end
   end

   // A disabled section keeps running until its busy flag drops, so no character is cut.
   always_comb begin
      tx_sect_next.start_ok = global_en_reg & tx_sect_en_reg;
      rx_sect_next.start_ok = global_en_reg & rx_sect_en_reg;
      tx_sect_next.run      = tx_sect_next.start_ok | (tx_sect_reg.run & tx_busy_i);
      rx_sect_next.run      = rx_sect_next.start_ok | (rx_sect_reg.run & rx_busy_i);
   end

   // Loopback feeds the receiver from the transmitter and parks the pin at the idle mark.
   always_comb begin
      rx_serial_next = loopback_reg ? tx_serial_i : serial_in_pin_i;
      out_pin_next   = loopback_reg ? 1'b1 : tx_serial_i;
   end

   // Section and pin registers.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         tx_sect_reg   <= '0;
         rx_sect_reg   <= '0;
         rx_serial_reg <= 1'b1;
         out_pin_reg   <= 1'b1;
      end else begin
         tx_sect_reg   <= tx_sect_next;
         rx_sect_reg   <= rx_sect_next;
         rx_serial_reg <= rx_serial_next;
         out_pin_reg   <= out_pin_next;
      end
   end

   // Level crossing detectors for both FIFOs.
   ucc_level_det #(
      .DIR (UCC_DIR_RISE)
   ) u_rx_det (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .level_i    (rx_fifo_level_i),
      .code_i     (rx_thr_reg),
      .cross_o    (rx_cross)
   );

   ucc_level_det #(
      .DIR (UCC_DIR_FALL)
   ) u_tx_det (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .level_i    (tx_fifo_level_i),
      .code_i     (tx_thr_reg),
      .cross_o    (tx_cross)
   );

   // Source order matches bits 4 to 10 of the status words.
   assign src_evt = {err_evt_i.overrun, err_evt_i.brk, err_evt_i.parity,
                     err_evt_i.framing, err_evt_i.rx_timeout, tx_cross, rx_cross};

   // Sticky raw flags; an event in the cycle of its clear wins so none is lost.
   genvar gi;
   generate
      for (gi = 0; gi < `UCC_SRC_N; gi++) begin : g_raw
         always_comb begin
            raw_next[gi] = src_evt[gi] | (raw_reg[gi] & ~clr_bits[gi]);
         end
      end
   endgenerate

   // The request line follows the next-state values so it never lags the status words.
   always_comb begin
      irq_next = |(raw_next & mask_next);
   end

   // Interrupt registers.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         raw_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         raw_reg <= raw_next;
         irq_reg <= irq_next;
      end
   end

   // Outputs straight from flops.
   assign prdata_o          = prdata_reg;
   assign pready_o          = pready_reg;
   assign pslverr_o         = pslverr_reg;
   assign tx_sect_o         = tx_sect_reg;
   assign rx_sect_o         = rx_sect_reg;
   assign loopback_enable_o = loopback_reg;
   assign rx_serial_o       = rx_serial_reg;
   assign serial_out_pin_o  = out_pin_reg;
   assign irq_o             = irq_reg;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   ctrl_reset_a: assert property ($fell(reset_i) |-> rx_sect_en_reg && tx_sect_en_reg)
      else $error("Section enables not set after reset.");
   port_reset_a: assert property ($fell(reset_i) |-> !global_en_reg && !loopback_reg)
      else $error("Global enable or loopback set after reset.");
   thr_reset_a: assert property ($fell(reset_i) |-> rx_thr_reg == `UCC_THR_RST && tx_thr_reg == `UCC_THR_RST)
      else $error("Thresholds not half-full after reset.");
   tx_drain_a: assert property (tx_sect_o.run && tx_busy_i |=> tx_sect_o.run)
      else $error("Transmitter stopped mid-character.");
   rx_drain_a: assert property (rx_sect_o.run && rx_busy_i |=> rx_sect_o.run)
      else $error("Receiver stopped mid-character.");
   global_off_a: assert property (!global_en_reg && !tx_busy_i ##1 !global_en_reg |-> !tx_sect_o.run)
      else $error("Transmitter runs while port disabled and idle.");
   loop_path_a: assert property (loopback_reg |=> rx_serial_o == $past(tx_serial_i) && serial_out_pin_o)
      else $error("Loopback path wrong.");
   half_mark_a: assert property (rx_thr_reg == `UCC_THR_RST && $past(rx_fifo_level_i) == `UCC_LVL_C2
                                 && rx_fifo_level_i == `UCC_LVL_C2 + 5'h01 |=> raw_reg[0])
      else $error("Half-full receive trigger missed on 9th entry.");
   // Any level that stands still must not fire; the first cycle after reset is left out on purpose.
   level_hold_a: assert property (rx_fifo_level_i == $past(rx_fifo_level_i) && !$past(reset_i)
                                  |-> !rx_cross)
      else $error("Receive level fired without a crossing.");
   rx_rsvd_a: assert property (rx_thr_reg > `UCC_THR_MAX |-> !rx_cross)
      else $error("Reserved receive code triggered.");
   tx_rsvd_a: assert property (tx_thr_reg > `UCC_THR_MAX |-> !tx_cross)
      else $error("Reserved transmit code triggered.");
   irq_line_a: assert property (irq_o == |(raw_reg & mask_reg))
      else $error("Interrupt line disagrees with masked status.");
   mask_block_a: assert property (mask_reg == 7'h00 |-> !irq_o)
      else $error("Interrupt forwarded with all sources masked.");
   mask_read_a: assert property (psel_i && !penable_i && paddr_i == `UCC_OFS_MASK
                                 |=> prdata_o[`UCC_SRC_MSB:`UCC_SRC_LSB] == $past(mask_reg))
      else $error("Mask read returned wrong value.");
   clear_bit_a: assert property (wr_acc && paddr_i == `UCC_OFS_CLR && pwdata_i[`UCC_SRC_LSB] && !rx_cross
                                 |=> !raw_reg[0])
      else $error("Clear did not drop receive level flag.");
   mis_write_a: assert property (wr_acc && paddr_i == `UCC_OFS_MIS && src_evt == '0
                                 |=> raw_reg == $past(raw_reg))
      else $error("Masked status write changed state.");
endmodule

//--- hdl/ucc_cfg.svh
// Offsets, field positions, reset values and trigger levels of the serial port control block.
`ifndef UCC_CFG_SVH
`define UCC_CFG_SVH

// Register byte offsets on the APB.
`define UCC_AW            12
`define UCC_OFS_CTRL      12'h030
`define UCC_OFS_THR       12'h034
`define UCC_OFS_MASK      12'h038
`define UCC_OFS_RAW       12'h03C
`define UCC_OFS_MIS       12'h040
`define UCC_OFS_CLR       12'h044

// Control register fields and reset values.
`define UCC_CTRL_RXE      9
`define UCC_CTRL_TXE      8
`define UCC_CTRL_LBE      7
`define UCC_CTRL_EN       0
`define UCC_RST_RXE       1'h1
`define UCC_RST_TXE       1'h1
`define UCC_RST_LBE       1'h0
`define UCC_RST_EN        1'h0

// Threshold register fields; code 3'h2 selects the half-full point.
`define UCC_THR_RX_MSB    5
`define UCC_THR_RX_LSB    3
`define UCC_THR_TX_MSB    2
`define UCC_THR_TX_LSB    0
`define UCC_THR_RST       3'h2
`define UCC_THR_MAX       3'h4

// Fill levels of a 16-entry FIFO for codes 1/8, 1/4, 1/2, 3/4 and 7/8.
`define UCC_LW            5
`define UCC_LVL_C0        5'h02
`define UCC_LVL_C1        5'h04
`define UCC_LVL_C2        5'h08
`define UCC_LVL_C3        5'h0C
`define UCC_LVL_C4        5'h0E

// Interrupt source field, bits 10:4 of mask, raw, masked and clear words.
`define UCC_SRC_N         7
`define UCC_SRC_MSB       10
`define UCC_SRC_LSB       4
`define UCC_RAW_RSVD      4'hF
`define UCC_RST_MASK      7'h00

`endif

//--- hdl/ucc_pkg.sv
// Types shared by the serial port control block and its level detector.
package ucc_pkg;
`include "ucc_cfg.svh"

   // Error and time-out events from the receive engine, one-cycle pulses.
   typedef struct packed {
      logic overrun;
      logic brk;
      logic parity;
      logic framing;
      logic rx_timeout;
   } ucc_err_evt_t;

   // Control of one serial section: may start a new character, and may run.
   typedef struct packed {
      logic start_ok;
      logic run;
   } ucc_sect_t;

   // Direction in which a fill level must pass its trigger point.
   typedef enum logic {
      UCC_DIR_RISE = 1'b0,
      UCC_DIR_FALL = 1'b1
   } ucc_dir_t;
endpackage

//--- hdl/ucc_level_det.sv
// Fill-level crossing detector for one FIFO and its threshold code.
`timescale 1ns/1ns
`include "ucc_cfg.svh"
module ucc_level_det #(
   parameter ucc_pkg::ucc_dir_t DIR = ucc_pkg::UCC_DIR_RISE
) (
   // Clock and reset.
   input  wire logic                 core_clk_i,
   input  wire logic                 reset_i,
   // Level and selected trigger code.
   input  wire logic [`UCC_LW-1:0]   level_i,
   input  wire logic [2:0]           code_i,
   // One-cycle pulse when the level passes the trigger point.
   output logic                      cross_o
);
   import ucc_pkg::*;

   logic [`UCC_LW-1:0] prev_reg;
   logic [`UCC_LW-1:0] prev_next;
   logic [`UCC_LW-1:0] point;
   logic               valid;
   logic               now_hit;
   logic               was_hit;

   // Decode the code into a fill level; reserved codes never trigger.
   always_comb begin
      valid = 1'b1;
      case (code_i)
         3'h0: point = `UCC_LVL_C0;
         3'h1: point = `UCC_LVL_C1;
         3'h2: point = `UCC_LVL_C2;
         3'h3: point = `UCC_LVL_C3;
         3'h4: point = `UCC_LVL_C4;
         default: begin
            point = `UCC_LVL_C0;
            valid = 1'b0;
         end
      endcase
   end

   // Receive side fires on the entry that goes past the point, so half-full fires on the 9th.
   // Transmit side fires when the level drains down to the point.
   always_comb begin
      prev_next = level_i;
      if (DIR == UCC_DIR_RISE) begin
         now_hit = level_i > point;
         was_hit = prev_reg > point;
      end else begin
         now_hit = level_i <= point;
         was_hit = prev_reg <= point;
      end
      cross_o = valid & now_hit & ~was_hit;
   end

   // Previous level register; starts empty so a full receive FIFO at reset counts as a pass.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= prev_next;
      end
   end
endmodule

//--- bench/ucc_far_dev.sv
// Behavioural model of the remote serial device that drives the receive pin.
`timescale 1ns/1ns
module ucc_far_dev (
   // Clock and reset.
   input  wire logic core_clk_i,
   input  wire logic reset_i,
   // Send request from the bench and the line toward the port.
   input  wire logic send_i,
   output logic      line_o
);
   logic [7:0] lfsr_reg;
   logic [7:0] lfsr_next;

   // A shifting pattern lets stale line data pass for fresh data only in cycles where the bit repeats.
   always_comb begin
      lfsr_next = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
   end

   // The line idles high outside a frame, as an idle serial line does.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         lfsr_reg <= 8'hA5;
         line_o   <= 1'h1;
      end else begin
         lfsr_reg <= lfsr_next;
         line_o   <= send_i ? lfsr_reg[0] : 1'h1;
      end
   end
endmodule

//--- bench/uart_control_irq_config_tb.sv
// Self-checking bench for the serial port control block.
`timescale 1ns/1ns
module uart_control_irq_config_tb;
   import ucc_pkg::*;
   logic         core_clk_i = 1'h0;
   logic         reset_i    = 1'h1;
   logic         psel, penable, pwrite, pready, pslverr, e;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, rd, m, x;
   logic         tx_busy, rx_busy, tx_ser, lb_rx, pin, out_pin, irq, loopback_enable, send, tp, pp;
   ucc_sect_t    tx_sect, rx_sect;
   logic [4:0]   tx_lvl, rx_lvl, ev;
   ucc_err_evt_t err;
   logic [31:0]  cv [4] = '{32'h301, 32'h201, 32'h101, 32'h300};
   integer       seed = 32'h5A10;
   int           fail_count = 0;
   int           n_compared = 0;

   // Free-running clock at 20 MHz.
   always #25 core_clk_i = ~core_clk_i;

   ucc_ctrl u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .tx_busy_i(tx_busy), .rx_busy_i(rx_busy), .tx_sect_o(tx_sect),
      .rx_sect_o(rx_sect), .loopback_enable_o(loopback_enable), .tx_serial_i(tx_ser), .serial_in_pin_i(pin),
      .rx_serial_o(lb_rx), .serial_out_pin_o(out_pin), .tx_fifo_level_i(tx_lvl),
      .rx_fifo_level_i(rx_lvl), .err_evt_i(err), .irq_o(irq));

   ucc_far_dev u_far (.core_clk_i(core_clk_i), .reset_i(reset_i), .send_i(send), .line_o(pin));

   // Prints the counts and the verdict, then ends the run.
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Compares one result against its expectation.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high at an edge.
   // There is no local limit: only the watchdog ends a wait that never finishes.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk_i);
      penable <= 1'h1;
      @(posedge core_clk_i);
      while (pready !== 1'h1) begin
         @(posedge core_clk_i);
      end
      rd = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   // Reads a register and compares the word.
   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rd, exp);
   endtask

   // Lets the section controls settle, then compares them.
   task sect_chk(input logic [1:0] t, input logic [1:0] r);
      repeat (2) @(posedge core_clk_i);
      chk(tx_sect, t);
      chk(rx_sect, r);
   endtask

   // Fill level at which each threshold code triggers in a 16-entry FIFO.
   function automatic logic [4:0] pt(input logic [2:0] c);
      case (c)
         3'h0: pt = 5'h02;
         3'h1: pt = 5'h04;
         3'h2: pt = 5'h08;
         3'h3: pt = 5'h0C;
         3'h4: pt = 5'h0E;
         default: pt = 5'h08;
      endcase
   endfunction

   // Main sequence.
   initial begin
      {psel, penable, pwrite, paddr, pwdata, tx_busy, rx_busy, tx_ser, send, rx_lvl, err} = '0;
      tx_lvl = 5'h10;
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'h0;
      rd_chk(12'h030, 32'h300);
      rd_chk(12'h034, 32'h12);
      rd_chk(12'h038, 32'h0);
      rd_chk(12'h03C, 32'hF);
      apb(1'h0, 12'h0FC, 32'h0);
      chk(e, 32'h1);
      sect_chk(2'h0, 2'h0);
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, 12'h030, cv[i]);
         sect_chk({2{cv[i][8] & cv[i][0]}}, {2{cv[i][9] & cv[i][0]}});
      end
      // A character in progress is finished after either kind of disable.
      for (int i = 0; i < 2; i++) begin
         apb(1'h1, 12'h030, 32'h301);
         tx_busy <= 1'h1;
         rx_busy <= 1'h1;
         apb(1'h1, 12'h030, i ? 32'h001 : 32'h300);
         sect_chk(2'h1, 2'h1);
         tx_busy <= 1'h0;
         sect_chk(2'h0, 2'h1);
         rx_busy <= 1'h0;
         sect_chk(2'h0, 2'h0);
      end
      // Serial paths, direct and looped back, with random transmit data.
      for (int lb = 0; lb < 2; lb++) begin
         apb(1'h1, 12'h030, lb ? 32'h381 : 32'h301);
         send <= 1'h1;
         @(posedge core_clk_i);
         chk(loopback_enable, lb);
         tp = tx_ser;
         pp = pin;
         repeat (8) begin
            @(posedge core_clk_i);
            chk(lb_rx, lb ? tp : pp);
            chk(out_pin, lb ? 1'h1 : tp);
            tp = tx_ser;
            pp = pin;
            tx_ser <= 1'($random(seed));
         end
         send <= 1'h0;
      end
      // Level crossings for every threshold code, reserved ones included; the port is off while reconfigured.
      apb(1'h1, 12'h030, 32'h300);
      apb(1'h1, 12'h038, 32'h30);
      for (int c = 0; c < 8; c++) begin
         apb(1'h1, 12'h034, {26'h0, 3'(c), 3'(c)});
         rx_lvl <= pt(3'(c));
         tx_lvl <= pt(3'(c)) + 5'h01;
         apb(1'h1, 12'h044, 32'h7F0);
         rx_lvl <= pt(3'(c)) + 5'h01;
         tx_lvl <= pt(3'(c));
         repeat (2) @(posedge core_clk_i);
         chk(irq, c < 5);
         rd_chk(12'h03C, (c < 5) ? 32'h3F : 32'hF);
         apb(1'h1, 12'h044, 32'h30);
         repeat (3) @(posedge core_clk_i);
         rd_chk(12'h03C, 32'hF);
      end
      // Random error events against random masks.
      repeat (6) begin
         m = $random(seed) & 32'h7F0;
         ev = 5'($random(seed));
         x = {21'h0, ev, 6'h00};
         apb(1'h1, 12'h044, 32'h7F0);
         apb(1'h1, 12'h038, m);
         rd_chk(12'h038, m);
         err <= ev;
         @(posedge core_clk_i);
         err <= '0;
         repeat (2) @(posedge core_clk_i);
         rd_chk(12'h03C, x | 32'hF);
         rd_chk(12'h040, x & m);
         chk(irq, |(x & m));
         apb(1'h1, 12'h040, 32'hFFFF_FFFF);
         rd_chk(12'h040, x & m);
         apb(1'h1, 12'h044, 32'h0);
         rd_chk(12'h03C, x | 32'hF);
      end
      // A reset in mid-run brings back the control, threshold, mask and section reset values, set up while the port is off.
      apb(1'h1, 12'h034, 32'h3F);
      apb(1'h1, 12'h038, 32'h7F0);
      apb(1'h1, 12'h030, 32'h381);
      reset_i <= 1'h1;
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'h0;
      rd_chk(12'h030, 32'h300);
      rd_chk(12'h034, 32'h12);
      rd_chk(12'h038, 32'h0);
      sect_chk(2'h0, 2'h0);
      finish_test;
   end

   // The whole sequence needs a few hundred cycles; this cuts a hang short.
   initial begin
      repeat (20000) @(posedge core_clk_i);
      fail_count++;
      finish_test;
   end
endmodule
